// ===== gpic_top.sv
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gpic_top (
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RESETN_IN,
	// Register port
	input wire logic [gpic_pkg::ADDR_W-1:0] REG_ADDR_IN,
	input wire logic [gpic_pkg::DATA_W-1:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [gpic_pkg::DATA_W-1:0] REG_RDATA_OUT,
	// Request sources
	input wire logic [gpic_pkg::CLS_W-1:0] LEVEL_REQ_IN,
	input wire logic [gpic_pkg::EVT_W-1:0] EVT_REQ_IN,
	input wire logic [gpic_pkg::XEXT_W-1:0] EXTRA_EXT_IN,
	input wire logic GLOBAL_IRQ_BLOCK_IN,
	// Core handshake
	input wire logic ACK_IN,
	input wire logic RETI_IN,
	output logic INT_REQ_OUT,
	output logic [gpic_pkg::SLOT_W-1:0] INT_SLOT_OUT,
	output logic [gpic_pkg::LVL_W-1:0] INT_LEVEL_OUT,
	output logic [gpic_pkg::NUM_LVL-1:0] ACTIVE_LEVELS_OUT,
	// Controller interrupt
	output logic IRQ_OUT
);
	logic [7:0] en_r [gpic_pkg::NUM_BANK];
	logic [5:0] lvl_lo_r;
	logic [5:0] lvl_hi_r;
	logic [1:0] xpol_r;
	logic [7:0] src_a_r;
	logic [7:0] src_b_r;
	logic [7:0] src_a_nxt;
	logic [7:0] src_b_nxt;
	logic [7:0] set_a;
	logic [7:0] set_b;
	logic [gpic_pkg::EVT_W-1:0] evt_prev_r;
	logic [gpic_pkg::EVT_W-1:0] evt_rise;
	logic [1:0] xs1_r;
	logic [1:0] xs2_r;
	logic [1:0] xs3_r;
	logic [1:0] xedge;
	logic [3:0] active_r;
	logic [3:0] active_nxt;
	logic [3:0] act_top;
	logic [3:0] lvl_hot;
	logic [2:0] stat_r;
	logic [2:0] stat_nxt;
	logic [2:0] stat_en_r;
	logic [2:0] stat_evt;
	logic [23:0] raw;
	logic [23:0] en_all;
	logic [23:0] req;
	logic [7:0] rd_mux;
	logic gate_ok;
	logic accept;

	gpic_arb_if arb ();

	////////////////////////////////////////////////////////////////////////////////
	// Write decode
	wire logic wr_lvl_lo = REG_WR_IN && REG_ADDR_IN == gpic_pkg::OFS_LVL_LO;
	wire logic wr_lvl_hi = REG_WR_IN && REG_ADDR_IN == gpic_pkg::OFS_LVL_HI;
	wire logic wr_xpol = REG_WR_IN && REG_ADDR_IN == gpic_pkg::OFS_XPOL;
	wire logic wr_src_a = REG_WR_IN && REG_ADDR_IN == gpic_pkg::OFS_SRC_A;
	wire logic wr_src_b = REG_WR_IN && REG_ADDR_IN == gpic_pkg::OFS_SRC_B;
	wire logic wr_stat_clr = REG_WR_IN && REG_ADDR_IN == gpic_pkg::OFS_STAT_CLR;
	wire logic wr_stat_en = REG_WR_IN && REG_ADDR_IN == gpic_pkg::OFS_STAT_EN;

	////////////////////////////////////////////////////////////////////////////////
	// Enable registers
	genvar b;
	generate
		for (b = 0; b < gpic_pkg::NUM_BANK; b++)
		begin : g_en
			localparam logic [7:0] MASK = (b == 0) ? gpic_pkg::EN_A_MASK : gpic_pkg::EN_MASK;
			wire logic wr_en = REG_WR_IN && REG_ADDR_IN == gpic_pkg::OFS_EN_A + 5'(b);
			always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
			begin
				if (!RESETN_IN)
					en_r[b] <= gpic_pkg::EN_RST;
				else if (wr_en)
					en_r[b] <= REG_WDATA_IN & MASK;
			end
			assign en_all[b * gpic_pkg::NUM_GRP +: gpic_pkg::NUM_GRP] = en_r[b][5:0];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Level and polarity registers
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			lvl_lo_r <= gpic_pkg::LVL_RST;
			lvl_hi_r <= gpic_pkg::LVL_RST;
			xpol_r <= gpic_pkg::XPOL_RST;
			stat_en_r <= gpic_pkg::STAT_EN_RST;
		end
		else
		begin
			if (wr_lvl_lo)
				lvl_lo_r <= REG_WDATA_IN[5:0];
			if (wr_lvl_hi)
				lvl_hi_r <= REG_WDATA_IN[5:0];
			if (wr_xpol)
				xpol_r <= REG_WDATA_IN[1:0];
			if (wr_stat_en)
				stat_en_r <= REG_WDATA_IN[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Edge capture
	assign evt_rise = EVT_REQ_IN & ~evt_prev_r;
	assign xedge = (xs2_r & ~xs3_r & xpol_r) | (~xs2_r & xs3_r & ~xpol_r);

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			evt_prev_r <= '0;
			xs1_r <= '0;
			xs2_r <= '0;
			xs3_r <= '0;
		end
		else
		begin
			evt_prev_r <= EVT_REQ_IN;
			xs1_r <= EXTRA_EXT_IN;
			xs2_r <= xs1_r;
			xs3_r <= xs2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Source flags
	always_comb
	begin
		set_a = evt_rise[7:0];
		set_b = '0;
		set_b[gpic_pkg::FB_CC] = evt_rise[gpic_pkg::EVT_CC];
		set_b[gpic_pkg::FB_ADW] = evt_rise[gpic_pkg::EVT_ADW];
		set_b[gpic_pkg::FB_XA] = xedge[0];
		set_b[gpic_pkg::FB_XB] = xedge[1];
	end

	// Zero clears, one keeps; a new edge beats the clear
	assign src_a_nxt = (wr_src_a ? src_a_r & REG_WDATA_IN : src_a_r) | set_a;
	assign src_b_nxt = ((wr_src_b ? src_b_r & REG_WDATA_IN : src_b_r) | set_b)
		& gpic_pkg::SRC_B_MASK;

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			src_a_r <= '0;
			src_b_r <= '0;
		end
		else
		begin
			src_a_r <= src_a_nxt;
			src_b_r <= src_b_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request vector
	always_comb
	begin
		raw = '0;
		raw[gpic_pkg::CLS_W-1:0] = LEVEL_REQ_IN;
		raw[gpic_pkg::SLOT_ADC] = src_a_r[gpic_pkg::FA_ADC];
		raw[gpic_pkg::SLOT_XA] = src_b_r[gpic_pkg::FB_XA];
		raw[gpic_pkg::SLOT_WT] = src_a_r[gpic_pkg::FA_WT];
		raw[gpic_pkg::SLOT_XB] = src_b_r[gpic_pkg::FB_XB];
		raw[gpic_pkg::SLOT_AV] = src_a_r[gpic_pkg::FA_AV];
		raw[gpic_pkg::SLOT_DV] = src_a_r[gpic_pkg::FA_DV];
		raw[gpic_pkg::SLOT_PW] = src_a_r[gpic_pkg::FA_PW];
		raw[gpic_pkg::SLOT_CC] = src_b_r[gpic_pkg::FB_CC];
		raw[gpic_pkg::SLOT_AH] = src_a_r[gpic_pkg::FA_AH];
		raw[gpic_pkg::SLOT_DH] = src_a_r[gpic_pkg::FA_DH];
		raw[gpic_pkg::SLOT_L24] = src_a_r[gpic_pkg::FA_L24];
		raw[gpic_pkg::SLOT_ADW] = src_b_r[gpic_pkg::FB_ADW];
	end

	assign gate_ok = en_r[0][gpic_pkg::GATE_BIT] && !GLOBAL_IRQ_BLOCK_IN;
	assign req = raw & en_all & gpic_pkg::IMPL_MASK & {24{gate_ok}};

	assign arb.req = req;
	assign arb.lvl_lo = lvl_lo_r;
	assign arb.lvl_hi = lvl_hi_r;
	assign arb.active = active_r;

	gpic_arbiter u_arb (
		.arb_io(arb.arb)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Active levels
	assign act_top = active_r[3] ? 4'h8 : active_r[2] ? 4'h4 : active_r[1] ? 4'h2
		: active_r[0] ? 4'h1 : 4'h0;
	assign lvl_hot = 4'h1 << INT_LEVEL_OUT;
	assign accept = ACK_IN && INT_REQ_OUT;
	assign active_nxt = (active_r & ~(RETI_IN ? act_top : 4'h0))
		| (accept ? lvl_hot : 4'h0);

	////////////////////////////////////////////////////////////////////////////////
	// Event status
	assign stat_evt = {RETI_IN && active_r == 4'h0, accept && active_r != 4'h0, accept};
	assign stat_nxt = (stat_r & ~(wr_stat_clr ? REG_WDATA_IN[2:0] : 3'h0)) | stat_evt;

	////////////////////////////////////////////////////////////////////////////////
	// Read mux
	always_comb
	begin
		case (REG_ADDR_IN)
			gpic_pkg::OFS_EN_A: rd_mux = en_r[0];
			gpic_pkg::OFS_EN_A + 5'h01: rd_mux = en_r[1];
			gpic_pkg::OFS_EN_A + 5'h02: rd_mux = en_r[2];
			gpic_pkg::OFS_EN_A + 5'h03: rd_mux = en_r[3];
			gpic_pkg::OFS_LVL_LO: rd_mux = {2'h0, lvl_lo_r};
			gpic_pkg::OFS_LVL_HI: rd_mux = {2'h0, lvl_hi_r};
			gpic_pkg::OFS_XPOL: rd_mux = {6'h00, xpol_r};
			gpic_pkg::OFS_SRC_A: rd_mux = src_a_r;
			gpic_pkg::OFS_SRC_B: rd_mux = src_b_r;
			gpic_pkg::OFS_STAT: rd_mux = {5'h00, stat_r};
			gpic_pkg::OFS_STAT_EN: rd_mux = {5'h00, stat_en_r};
			gpic_pkg::OFS_STATE: rd_mux = {INT_REQ_OUT, 1'h0, INT_LEVEL_OUT, active_r};
			default: rd_mux = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output registers
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			active_r <= '0;
			stat_r <= '0;
			IRQ_OUT <= 1'h0;
			REG_RDATA_OUT <= '0;
			INT_REQ_OUT <= 1'h0;
			INT_SLOT_OUT <= '0;
			INT_LEVEL_OUT <= '0;
			ACTIVE_LEVELS_OUT <= '0;
		end
		else
		begin
			active_r <= active_nxt;
			stat_r <= stat_nxt;
			IRQ_OUT <= |(stat_r & stat_en_r);
			REG_RDATA_OUT <= REG_RD_IN ? rd_mux : 8'h00;
			INT_REQ_OUT <= arb.win_valid && !accept;
			INT_SLOT_OUT <= arb.win_slot;
			INT_LEVEL_OUT <= arb.win_level;
			ACTIVE_LEVELS_OUT <= active_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	sequence s_first_entry;
		ACK_IN && INT_REQ_OUT && active_r == 4'h0;
	endsequence

	sequence s_lone_return;
		RETI_IN && !ACK_IN;
	endsequence

	enable_pass_a: assert property (INT_REQ_OUT |-> $past(en_all[arb.win_slot]))
		else $error("request from a disabled slot");
	edge_flag_a: assert property (evt_rise[gpic_pkg::FA_L24] |=> src_a_r[gpic_pkg::FA_L24]
		##1 (src_a_r[gpic_pkg::FA_L24] || $past(wr_src_a)))
		else $error("rising edge not flagged");
	flag_hold_a: assert property (!wr_src_a |=> (src_a_r & $past(src_a_r)) == $past(src_a_r))
		else $error("source flag lost without a write");
	no_hw_clear_a: assert property (accept && !wr_src_b |=> (src_b_r & $past(src_b_r)) == $past(src_b_r))
		else $error("handler entry cleared a flag");
	unimpl_slot_a: assert property (INT_REQ_OUT |-> gpic_pkg::IMPL_MASK[INT_SLOT_OUT])
		else $error("unimplemented slot requested");
	gate_block_a: assert property (!en_r[0][gpic_pkg::GATE_BIT] |=> !INT_REQ_OUT)
		else $error("request with global gate off");
	block_input_a: assert property (GLOBAL_IRQ_BLOCK_IN |=> !INT_REQ_OUT)
		else $error("request while globally blocked");
	preempt_level_a: assert property (INT_REQ_OUT |-> ($past(active_r) >> INT_LEVEL_OUT) == 4'h0)
		else $error("request not above active level");
	entry_mark_a: assert property (s_first_entry |=> active_r != 4'h0 && !INT_REQ_OUT)
		else $error("handler entry not recorded");
	nest_return_a: assert property (s_lone_return ##0 $onehot(active_r) |=> active_r == 4'h0)
		else $error("return left a level active");
endmodule // gpic_top
`default_nettype wire

// ===== gpic_pkg.sv
// Overview of operation
// - Four writable enable registers; one bit per source, one passes, zero blocks.
// - Block-generated sources are flagged on a rising edge of their request line.
// - Each edge request latches into a source flag that stays until software clears it.
// - Six groups; group n holds enable bit n of all four enable registers.
// - Each group takes one of four levels from its bits in two level registers.
// - A running routine is preempted only by a strictly higher level request.
// - Among simultaneous requests of different level the higher level wins.
// - Equal levels use scan order: group 0 first, then enable register a to d.
// - Bit 7 of enable register a gates all interrupts globally.
// - The global block input overrides the gate and blocks all requests; an acknowledge in the cycle it rises is still accepted.
// - One active flag per level; return clears the highest active flag only.
// - Source flags are never cleared by hardware on handler entry.
`default_nettype none
package gpic_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int NUM_GRP = 6;
	localparam int NUM_BANK = 4;
	localparam int NUM_SLOT = 24;
	localparam int NUM_LVL = 4;
	localparam int LVL_W = 2;
	localparam int SLOT_W = 5;
	localparam int EVT_W = 10;
	localparam int CLS_W = 5;
	localparam int XEXT_W = 2;
	localparam int STAT_W = 3;
	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [4:0] OFS_EN_A = 5'h00;
	localparam logic [4:0] OFS_LVL_HI = 5'h04;
	localparam logic [4:0] OFS_XPOL = 5'h05;
	localparam logic [4:0] OFS_STAT = 5'h06;
	localparam logic [4:0] OFS_STAT_CLR = 5'h07;
	localparam logic [4:0] OFS_SRC_A = 5'h08;
	localparam logic [4:0] OFS_STAT_EN = 5'h09;
	localparam logic [4:0] OFS_STATE = 5'h0A;
	localparam logic [4:0] OFS_SRC_B = 5'h10;
	localparam logic [4:0] OFS_LVL_LO = 5'h18;
	////////////////////////////////////////////////////////////////////////////////
	// Field layout and reset values
	localparam int GATE_BIT = 7;
	localparam logic [7:0] EN_A_MASK = 8'hBF;
	localparam logic [7:0] EN_MASK = 8'h3F;
	localparam logic [7:0] SRC_B_MASK = 8'hF0;
	localparam logic [7:0] EN_RST = 8'h00;
	localparam logic [5:0] LVL_RST = 6'h00;
	localparam logic [1:0] XPOL_RST = 2'h3;
	localparam logic [2:0] STAT_EN_RST = 3'h0;
	localparam logic [23:0] IMPL_MASK = 24'hC3CFBF;
	localparam int FA_DH = 0;
	localparam int FA_AH = 1;
	localparam int FA_PW = 2;
	localparam int FA_DV = 3;
	localparam int FA_AV = 4;
	localparam int FA_WT = 5;
	localparam int FA_ADC = 6;
	localparam int FA_L24 = 7;
	localparam int FB_XA = 4;
	localparam int FB_XB = 5;
	localparam int FB_ADW = 6;
	localparam int FB_CC = 7;
	localparam int EVT_CC = 8;
	localparam int EVT_ADW = 9;
	localparam int SLOT_ADC = 5;
	localparam int SLOT_XA = 7;
	localparam int SLOT_WT = 8;
	localparam int SLOT_XB = 9;
	localparam int SLOT_AV = 10;
	localparam int SLOT_DV = 11;
	localparam int SLOT_PW = 14;
	localparam int SLOT_CC = 15;
	localparam int SLOT_AH = 16;
	localparam int SLOT_DH = 17;
	localparam int SLOT_L24 = 22;
	localparam int SLOT_ADW = 23;
	localparam int ST_ACCEPT = 0;
	localparam int ST_NEST = 1;
	localparam int ST_STRAY = 2;
endpackage
`default_nettype wire

// ===== gpic_arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gpic_arb_if;
	logic [gpic_pkg::NUM_SLOT-1:0] req;
	logic [gpic_pkg::NUM_GRP-1:0] lvl_lo;
	logic [gpic_pkg::NUM_GRP-1:0] lvl_hi;
	logic [gpic_pkg::NUM_LVL-1:0] active;
	logic win_valid;
	logic [gpic_pkg::SLOT_W-1:0] win_slot;
	logic [gpic_pkg::LVL_W-1:0] win_level;
	modport arb (input req, lvl_lo, lvl_hi, active, output win_valid, win_slot, win_level);
	modport ctl (output req, lvl_lo, lvl_hi, active, input win_valid, win_slot, win_level);
endinterface // gpic_arb_if
`default_nettype wire

// ===== gpic_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module gpic_arbiter (
	// Arbitration port
	gpic_arb_if.arb arb_io
);
	logic [gpic_pkg::LVL_W-1:0] grp_lvl [gpic_pkg::NUM_GRP];
	logic found;
	logic [gpic_pkg::LVL_W-1:0] best;
	logic [gpic_pkg::SLOT_W-1:0] slot;

	////////////////////////////////////////////////////////////////////////////////
	// Group levels
	genvar g;
	generate
		for (g = 0; g < gpic_pkg::NUM_GRP; g++)
		begin : g_lvl
			assign grp_lvl[g] = {arb_io.lvl_hi[g], arb_io.lvl_lo[g]};
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Scan in group order, keep first of the highest level
	always_comb
	begin
		logic busy;
		logic [gpic_pkg::LVL_W-1:0] ceil;
		int s;
		busy = |arb_io.active;
		ceil = '0;
		s = 0;
		found = 1'h0;
		best = '0;
		slot = '0;
		for (int l = 0; l < gpic_pkg::NUM_LVL; l++)
		begin
			if (arb_io.active[l])
				ceil = gpic_pkg::LVL_W'(l);
		end
		for (int gi = 0; gi < gpic_pkg::NUM_GRP; gi++)
		begin
			for (int b = 0; b < gpic_pkg::NUM_BANK; b++)
			begin
				s = b * gpic_pkg::NUM_GRP + gi;
				if (arb_io.req[s] && (!busy || grp_lvl[gi] > ceil)
					&& (!found || grp_lvl[gi] > best))
				begin
					found = 1'h1;
					best = grp_lvl[gi];
					slot = gpic_pkg::SLOT_W'(s);
				end
			end
		end
	end

	assign arb_io.win_valid = found;
	assign arb_io.win_slot = slot;
	assign arb_io.win_level = best;
endmodule // gpic_arbiter
`default_nettype wire

// ===== gpic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpic_core_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Controller side
	input wire logic int_req_in,
	output logic ack_out,
	// Bench control
	input wire logic ack_en_in,
	input wire logic [3:0] delay_in
);
	logic [3:0] cnt_r;
	////////////////////////////////////////////////////////////////////////////////
	// Handler entry after a chosen wait, one pulse per presented request
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ack_out <= 1'b0;
			cnt_r <= 4'h0;
		end
		else
		begin
			ack_out <= 1'b0;
			if (ack_out || !int_req_in || !ack_en_in)
				cnt_r <= 4'h0;
			else if (cnt_r == delay_in)
				ack_out <= 1'b1;
			else
				cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule // gpic_core_model
`default_nettype wire

// ===== grouped_priority_interrupt_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module grouped_priority_interrupt_ctrl_tb;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [4:0] lreq = 5'h00;
	logic [9:0] evt = 10'h000;
	logic [1:0] xext = 2'h0;
	logic blk = 1'b0;
	logic reti = 1'b0;
	logic ack_en = 1'b0;
	logic [3:0] delay = 4'h0;
	logic ack, int_req, irq;
	logic [7:0] rdata;
	logic [4:0] slot;
	logic [1:0] lvl;
	logic [3:0] act;
	logic [7:0] m_en [4];
	int err_total = 0, checks_done = 0, seed = 32'hBFF1F772;
	int m_fa = 0, m_fb = 0, m_lo, m_hi, m_act = 0, m_stat = 0, m_sen = 0, tmp;
	int map [24] = '{16, 17, 18, 19, 20, 6, -1, 12, 5, 13, 4, 3, -1, -1, 2, 15, 1, 0,
		-1, -1, -1, -1, 7, 14};
	logic [4:0] r_adr [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h09, 5'h18,
		5'h1F, 5'h06, 5'h07, 5'h08, 5'h10, 5'h0A};
	logic [7:0] r_rst [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] r_msk [14] = '{8'hBF, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h03, 8'h07, 8'h3F,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	always #5 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////////////////////
	// Device and core model
	gpic_top dut (.REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
		.LEVEL_REQ_IN(lreq), .EVT_REQ_IN(evt), .EXTRA_EXT_IN(xext),
		.GLOBAL_IRQ_BLOCK_IN(blk), .ACK_IN(ack), .RETI_IN(reti), .INT_REQ_OUT(int_req),
		.INT_SLOT_OUT(slot), .INT_LEVEL_OUT(lvl), .ACTIVE_LEVELS_OUT(act), .IRQ_OUT(irq));
	gpic_core_model core (.clk_in(ref_clk), .resetn_in(resetn), .int_req_in(int_req),
		.ack_out(ack), .ack_en_in(ack_en), .delay_in(delay));
	////////////////////////////////////////////////////////////////////////////////
	// Compare and bus tasks
	task automatic tally(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		tally(n, e, g);
	endtask
	task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] g);
		tally(n, e, g);
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		chk_reg($sformatf("reg %h", a), e, rdata);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Reference arbitration
	function automatic int win(output int l);
		int src, top, s, best, lv;
		src = m_fa | (m_fb << 8) | (int'(lreq) << 16);
		top = -1;
		l = -1;
		best = -1;
		for (int k = 0; k < 4; k++)
			if (m_act[k])
				top = k;
		if (m_en[0][7] && !blk)
			for (int g = 0; g < 6; g++)
				for (int b = 0; b < 4; b++)
				begin
					s = b * 6 + g;
					lv = ((m_hi >> g) & 1) * 2 + ((m_lo >> g) & 1);
					if (map[s] >= 0 && src[map[s]] && m_en[b][g] && lv > top && lv > l)
					begin
						l = lv;
						best = s;
					end
				end
		return best;
	endfunction
	task automatic chk_win;
		int s, l;
		repeat (3) @(posedge ref_clk);
		#1;
		s = win(l);
		chk_pin("int_req", {7'h0, s >= 0}, {7'h0, int_req});
		if (s >= 0)
		begin
			chk_pin("int_slot", s[7:0], {3'h0, slot});
			chk_pin("int_level", l[7:0], {6'h0, lvl});
		end
		chk_pin("active", m_act[7:0], {4'h0, act});
		chk_pin("irq", {7'h0, |(m_stat & m_sen)}, {7'h0, irq});
	endtask
	task automatic take_ack;
		int s, l, i;
		s = win(l);
		ack_en <= 1'b1;
		for (i = 0; i < 20 && ack !== 1'b1; i++)
			@(posedge ref_clk);
		ack_en <= 1'b0;
		chk_pin("ack", 8'h01, {7'h0, ack});
		m_stat |= (m_act != 0) ? 3 : 1;
		m_act |= 1 << l;
	endtask
	task automatic do_reti;
		int k;
		@(posedge ref_clk);
		reti <= 1'b1;
		@(posedge ref_clk);
		reti <= 1'b0;
		if (m_act == 0)
			m_stat |= 4;
		for (k = 3; k >= 0 && !m_act[k]; k--)
			;
		if (k >= 0)
			m_act &= ~(1 << k);
	endtask
	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#400000;
		err_total++;
		conclude;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	initial
	begin
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 14; i++)
		begin
			rd_chk(r_adr[i], r_rst[i]);
			wr_reg(r_adr[i], 8'hFF);
			rd_chk(r_adr[i], r_msk[i]);
			wr_reg(r_adr[i], r_rst[i]);
		end
		// Held request lines flag once only
		@(posedge ref_clk);
		evt <= 10'h3FF;
		repeat (3) @(posedge ref_clk);
		rd_chk(gpic_pkg::OFS_SRC_A, 8'hFF);
		rd_chk(gpic_pkg::OFS_SRC_B, 8'hC0);
		wr_reg(gpic_pkg::OFS_SRC_A, 8'h0F);
		wr_reg(gpic_pkg::OFS_SRC_B, 8'h00);
		rd_chk(gpic_pkg::OFS_SRC_A, 8'h0F);
		rd_chk(gpic_pkg::OFS_SRC_B, 8'h00);
		wr_reg(gpic_pkg::OFS_SRC_A, 8'h00);
		evt <= 10'h000;
		// Extra external pins, both polarities
		xext <= 2'b01;
		repeat (5) @(posedge ref_clk);
		rd_chk(gpic_pkg::OFS_SRC_B, 8'h10);
		wr_reg(gpic_pkg::OFS_XPOL, 8'h00);
		wr_reg(gpic_pkg::OFS_SRC_B, 8'h00);
		xext <= 2'b10;
		repeat (5) @(posedge ref_clk);
		xext <= 2'b00;
		repeat (5) @(posedge ref_clk);
		rd_chk(gpic_pkg::OFS_SRC_B, 8'h30);
		wr_reg(gpic_pkg::OFS_SRC_B, 8'h00);
		// Random arbitration, nesting and returns
		repeat (16)
		begin
			for (int b = 0; b < 4; b++)
			begin
				m_en[b] = 8'($random(seed)) & ((b == 0) ? 8'hBF : 8'h3F);
				if (b == 0 && ($random(seed) & 3) != 0)
					m_en[0][7] = 1'b1;
				wr_reg(gpic_pkg::OFS_EN_A + 5'(b), m_en[b]);
			end
			m_lo = $random(seed) & 63;
			m_hi = $random(seed) & 63;
			m_sen = $random(seed) & 7;
			wr_reg(gpic_pkg::OFS_LVL_LO, m_lo[7:0]);
			wr_reg(gpic_pkg::OFS_LVL_HI, m_hi[7:0]);
			wr_reg(gpic_pkg::OFS_STAT_EN, m_sen[7:0]);
			tmp = $random(seed);
			delay <= 4'($random(seed)) & 4'h3;
			lreq <= 5'($random(seed));
			blk <= (($random(seed) & 3) == 0);
			evt <= tmp[9:0];
			m_fa |= tmp & 255;
			m_fb |= (((tmp >> 8) & 1) << 7) | (((tmp >> 9) & 1) << 6);
			@(posedge ref_clk);
			evt <= 10'h000;
			chk_win;
			repeat (4)
				if (win(tmp) >= 0)
				begin
					take_ack;
					chk_win;
				end
			rd_chk(gpic_pkg::OFS_SRC_A, m_fa[7:0]);
			rd_chk(gpic_pkg::OFS_SRC_B, m_fb[7:0]);
			rd_chk(gpic_pkg::OFS_STAT, m_stat[7:0]);
			while (m_act != 0)
			begin
				do_reti;
				chk_win;
			end
			do_reti;
			rd_chk(gpic_pkg::OFS_STAT, m_stat[7:0]);
			wr_reg(gpic_pkg::OFS_STAT_CLR, 8'h07);
			wr_reg(gpic_pkg::OFS_SRC_A, 8'h00);
			wr_reg(gpic_pkg::OFS_SRC_B, 8'h00);
			m_stat = 0;
			m_fa = 0;
			m_fb = 0;
			chk_win;
		end
		conclude;
	end
endmodule // grouped_priority_interrupt_ctrl_tb
`default_nettype wire
